// [bench/rif_monitor.sv]
// checker for the radio interrupt block, watching its ports only
// assumes one clk_sys domain, bound from tb_top
`timescale 1ns/1ps
`include "rif_defines.vh"
module rif_monitor (
  input wire       clk_sys,
  input wire       rst,
  input wire       ce,
  input wire [7:0] addr,
  input wire [7:0] wr_data,
  input wire       wr_stb,
  input wire       rd_stb,
  input wire [7:0] rd_data,
  input wire       tx_underflow_evt,
  input wire       rx_overflow_evt,
  input wire       rx_timeout_evt,
  input wire       packet_done_evt,
  input wire       carrier_sense_evt,
  input wire       preamble_quality_evt,
  input wire       clear_channel_evt,
  input wire       sync_word_evt,
  input wire       radio_irq,
  input wire [7:0] radio_irq_enable_mask,
  input wire [7:0] radio_irq_pending_flags,
  input wire       rx_timeout_pulse
);
  // flag set and clear causes, by bit
  wire [7:0] fl = radio_irq_pending_flags;
  wire [7:0] mk = radio_irq_enable_mask;
  wire       tmo = rx_timeout_evt | rx_timeout_pulse;
  wire       ovr = tx_underflow_evt | rx_overflow_evt;
  wire [7:0] set_v = {tx_underflow_evt, rx_overflow_evt, tmo, packet_done_evt | ovr,
                      carrier_sense_evt, preamble_quality_evt, clear_channel_evt, sync_word_evt};
  wire       pend_wr = wr_stb && addr == `RIF_ADDR_PEND;
  wire [7:0] clr_v = pend_wr ? ~wr_data : 8'h00;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_mask_wr; ce && wr_stb && addr == `RIF_ADDR_MASK; endsequence
  sequence s_mask_rd; ce && rd_stb && addr == `RIF_ADDR_MASK; endsequence
  property p_irq; radio_irq == |(mk & fl); endproperty
  property p_mask; s_mask_wr |=> mk == $past(wr_data); endproperty
  property p_rd; s_mask_rd |=> rd_data == $past(mk); endproperty
  property p_rd_idle; ce && !rd_stb |=> rd_data == 8'h00; endproperty
  property p_ovf; ce && rx_overflow_evt |=> fl[6] && fl[4]; endproperty
  property p_unf; ce && tx_underflow_evt |=> fl[7] && fl[4]; endproperty
  property p_set; ce && (|set_v[2:0]) |=> (fl[2:0] & $past(set_v[2:0])) == $past(set_v[2:0]);
  endproperty
  property p_tmo; ce && tmo |=> fl[5]; endproperty
  property p_clr; ce && pend_wr |=> fl == (($past(fl) & $past(wr_data)) | $past(set_v));
  endproperty
  property p_hold; ce |=> ($past(fl) & ~fl & ~$past(clr_v)) == 8'h00; endproperty
  a_irq: assert property (p_irq) else $error("irq level wrong");
  a_mask: assert property (p_mask) else $error("mask write lost");
  a_rd: assert property (p_rd) else $error("mask read wrong");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_ovf: assert property (p_ovf) else $error("overflow flags");
  a_unf: assert property (p_unf) else $error("underflow flags");
  a_set: assert property (p_set) else $error("event flag not set");
  a_tmo: assert property (p_tmo) else $error("timeout flag");
  a_clr: assert property (p_clr) else $error("flag clear wrong");
  a_hold: assert property (p_hold) else $error("flag dropped");
endmodule // rif_monitor

// [bench/rif_radio_model.sv]
// radio event source model: request bits are registered into event pulses of the same length
// assumes requests come from the bench synchronous to clk_sys
`timescale 1ns/1ps
module rif_radio_model (
  input  wire       clk_sys,
  input  wire       rst,
  input  wire [7:0] fire,
  output reg  [7:0] evt
);
  // pulses launch after an edge and last as long as the request; pairing is the device's job
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      evt <= 8'h00;
    end else begin
      evt <= fire;
    end
  end
endmodule // rif_radio_model

// [bench/tb_top.sv]
// self-checking bench for the radio interrupt block
// assumes rif_top, its defines header and the radio event model
`timescale 1ns/1ps
`include "rif_defines.vh"
module tb_top;
  reg        clk_sys = 1'b0;
  reg        rst = 1'b1;
  reg  [7:0] addr = 8'h00;
  reg  [7:0] wr_data = 8'h00;
  reg        wr_stb = 1'b0;
  reg        rd_stb = 1'b0;
  reg  [7:0] fire = 8'h00;
  reg        rx_active = 1'b0;
  wire [7:0] evt;
  wire [7:0] rd_data;
  wire [7:0] flags;
  wire       radio_irq;
  integer    mismatches = 0;
  integer    check_count = 0;
  integer    k;
  integer    n;
  reg  [7:0] pat;

  // 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;

  rif_radio_model i_rif_radio_model (.clk_sys(clk_sys), .rst(rst), .fire(fire), .evt(evt));

  rif_top i_rif_top (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .tx_underflow_evt(evt[7]), .rx_overflow_evt(evt[6]), .rx_timeout_evt(evt[5]),
    .packet_done_evt(evt[4]), .carrier_sense_evt(evt[3]), .preamble_quality_evt(evt[2]),
    .clear_channel_evt(evt[1]), .sync_word_evt(evt[0]), .rx_active(rx_active),
    .radio_irq(radio_irq), .radio_irq_enable_mask(), .radio_irq_pending_flags(flags),
    .rx_timeout_pulse());

  // compare and count
  task chk(input [7:0] got, input [7:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // one-cycle register write
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_sys);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge clk_sys);
      wr_stb <= 1'b0;
    end
  endtask

  // one-cycle read, data checked in the following cycle
  task rd(input [7:0] a, input [7:0] exp);
    begin
      @(posedge clk_sys);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk_sys);
      rd_stb <= 1'b0;
      #1;
      chk(rd_data, exp);
    end
  endtask

  // fire event pulses and wait until the flags have landed
  task pulse(input [7:0] v);
    begin
      @(posedge clk_sys);
      fire <= v;
      @(posedge clk_sys);
      fire <= 8'h00;
      @(posedge clk_sys);
      #1;
    end
  endtask

  // verdict and end of run
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`RIF_ADDR_MASK, 8'h00);
    rd(`RIF_ADDR_PEND, 8'h00);
    rd(8'h40, 8'h00);
    for (k = 0; k < 8; k = k + 1) begin
      pat = (8'h01 << k) | ((k >= 6) ? 8'h10 : 8'h00);
      wr(`RIF_ADDR_MASK, ~pat);
      pulse(8'h01 << k);
      rd(`RIF_ADDR_PEND, pat);
      chk({7'h00, radio_irq}, 8'h00);
      wr(`RIF_ADDR_MASK, 8'h01 << k);
      rd(`RIF_ADDR_MASK, 8'h01 << k);
      chk({7'h00, radio_irq}, 8'h01);
      wr(`RIF_ADDR_PEND, 8'hFF);
      rd(`RIF_ADDR_PEND, pat);
      wr(`RIF_ADDR_PEND, ~pat);
      rd(`RIF_ADDR_PEND, 8'h00);
      chk({7'h00, radio_irq}, 8'h00);
    end
    // receive period of four cycles, then wait for the timeout flag
    wr(`RIF_ADDR_TMO_LO, 8'h04);
    wr(`RIF_ADDR_TMO_HI, 8'h00);
    wr(`RIF_ADDR_TMO_CTRL, 8'h01);
    wr(`RIF_ADDR_MASK, 8'h20);
    @(posedge clk_sys);
    rx_active <= 1'b1;
    n = 0;
    while (flags[5] !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1;
      n = n + 1;
    end
    if (n == 20) begin
      mismatches = mismatches + 1;
      end_of_test;
    end
    rx_active <= 1'b0;
    rd(`RIF_ADDR_PEND, 8'h20);
    chk({7'h00, radio_irq}, 8'h01);
    end_of_test;
  end
endmodule // tb_top

bind rif_top rif_monitor i_rif_monitor (.*);

// [hw/rif_defines.vh]
// register map, field positions and reset values of the radio interrupt block
// assumes an 8-bit register bus addressed by byte
`ifndef RIF_DEFINES_VH
`define RIF_DEFINES_VH

// register addresses
`define RIF_ADDR_MASK      8'h91
`define RIF_ADDR_PEND      8'hE9
`define RIF_ADDR_TMO_LO    8'hEA
`define RIF_ADDR_TMO_HI    8'hEB
`define RIF_ADDR_TMO_CTRL  8'hEC
`define RIF_ADDR_RAW       8'hED
`define RIF_ADDR_CNT_LO    8'hEE
`define RIF_ADDR_CNT_HI    8'hEF

// bit positions shared by mask, pending and raw registers
`define RIF_BIT_TXUNF      7
`define RIF_BIT_RXOVF      6
`define RIF_BIT_TIMEOUT    5
`define RIF_BIT_DONE       4
`define RIF_BIT_CS         3
`define RIF_BIT_PQT        2
`define RIF_BIT_CCA        1
`define RIF_BIT_SFD        0

// timeout control fields
`define RIF_CTRL_RUN       0
`define RIF_CTRL_SYNC_RST  1

// reset values, unmapped read value and counter constants
`define RIF_MASK_RST       8'h00
`define RIF_PEND_RST       1'b0
`define RIF_CTRL_RST       8'h00
`define RIF_TMO_RST        16'h0100
`define RIF_CNT_RST        16'h0000
`define RIF_RD_RST         8'h00
`define RIF_RD_UNMAPPED    8'h00
`define RIF_CNT_STEP       16'h0001
`define RIF_TMO_NONE       16'h0000

`endif

// [hw/rif_flag_bit.v]
// one sticky pending flag: hardware set, software clear
// assumes set and clear are one-cycle qualified strobes on clk_sys
`timescale 1ns/1ps
`include "rif_defines.vh"

module rif_flag_bit (
  input  wire clk_sys,
  input  wire rst,
  input  wire ce,
  input  wire set,
  input  wire clr,
  output reg  flag
);

  // set beats a clear in the same cycle so no event is lost
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flag <= `RIF_PEND_RST;
    end else if (ce) begin
      if (set) begin
        flag <= 1'b1;
      end else if (clr) begin
        flag <= 1'b0;
      end
    end
  end

endmodule // rif_flag_bit

// [hw/rif_top.v]
// radio interrupt flags, enable mask, receive timeout timer and irq output
// assumes radio event inputs are one-cycle pulses synchronous to clk_sys
// assumes the register master never raises both strobes in one cycle
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "rif_defines.vh"

module rif_top #(
  parameter ADDR_W = 8,
  parameter DATA_W = 8,
  parameter TMO_W  = 16
) (
  input  wire              clk_sys,
  input  wire              rst,
  input  wire              ce,
  // register port
  input  wire [ADDR_W-1:0] addr,
  input  wire [DATA_W-1:0] wr_data,
  input  wire              wr_stb,
  input  wire              rd_stb,
  output reg  [DATA_W-1:0] rd_data,
  // radio event sources
  input  wire              tx_underflow_evt,
  input  wire              rx_overflow_evt,
  input  wire              rx_timeout_evt,
  input  wire              packet_done_evt,
  input  wire              carrier_sense_evt,
  input  wire              preamble_quality_evt,
  input  wire              clear_channel_evt,
  input  wire              sync_word_evt,
  input  wire              rx_active,
  // interrupt side
  output wire              radio_irq,
  output reg  [7:0]        radio_irq_enable_mask,
  output wire [7:0]        radio_irq_pending_flags,
  output wire              rx_timeout_pulse
);

  // address match, used by every register decode
  function rif_hit;
    input [ADDR_W-1:0] a;
    input [7:0]        target;
    begin
      rif_hit = (a == target[ADDR_W-1:0]);
    end
  endfunction

  // named mask fields
  wire tx_underflow_enable;
  wire rx_overflow_enable;
  wire rx_timeout_enable;
  wire packet_done_enable;
  wire carrier_sense_enable;
  wire preamble_quality_enable;
  wire clear_channel_enable;
  wire sync_word_enable;

  // named pending fields
  wire tx_underflow_pending;
  wire rx_overflow_pending;
  wire preamble_quality_pending;
  wire clear_channel_pending;
  wire sync_word_pending;

  // register decode
  wire wr_mask;
  wire wr_pend;
  wire wr_tmo_lo;
  wire wr_tmo_hi;
  wire wr_ctrl;

  // timeout timer state
  reg  [TMO_W-1:0] tmo_period;
  reg  [TMO_W-1:0] tmo_count;
  reg  [7:0]       tmo_ctrl;
  reg  [TMO_W-1:0] next_tmo_count;
  reg              tmo_fire;
  wire             tmo_run;
  wire             tmo_restart;
  wire [TMO_W-1:0] tmo_last;

  // flag set and clear vectors
  reg  [7:0] set_vec;
  wire [7:0] clr_vec;
  wire [7:0] raw_vec;
  wire [7:0] pend;

  // read multiplexer
  reg  [DATA_W-1:0] next_rd_data;

  // write strobes per register
  assign wr_mask   = wr_stb & rif_hit(addr, `RIF_ADDR_MASK);
  assign wr_pend   = wr_stb & rif_hit(addr, `RIF_ADDR_PEND);
  assign wr_tmo_lo = wr_stb & rif_hit(addr, `RIF_ADDR_TMO_LO);
  assign wr_tmo_hi = wr_stb & rif_hit(addr, `RIF_ADDR_TMO_HI);
  assign wr_ctrl   = wr_stb & rif_hit(addr, `RIF_ADDR_TMO_CTRL);

  // mask register, plain read/write
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      radio_irq_enable_mask <= `RIF_MASK_RST;
    end else if (ce && wr_mask) begin
      radio_irq_enable_mask <= wr_data[7:0];
    end
  end

  // mask field views
  assign tx_underflow_enable     = radio_irq_enable_mask[`RIF_BIT_TXUNF];
  assign rx_overflow_enable      = radio_irq_enable_mask[`RIF_BIT_RXOVF];
  assign rx_timeout_enable       = radio_irq_enable_mask[`RIF_BIT_TIMEOUT];
  assign packet_done_enable      = radio_irq_enable_mask[`RIF_BIT_DONE];
  assign carrier_sense_enable    = radio_irq_enable_mask[`RIF_BIT_CS];
  assign preamble_quality_enable = radio_irq_enable_mask[`RIF_BIT_PQT];
  assign clear_channel_enable    = radio_irq_enable_mask[`RIF_BIT_CCA];
  assign sync_word_enable        = radio_irq_enable_mask[`RIF_BIT_SFD];

  // timeout period, low and high byte
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tmo_period <= `RIF_TMO_RST;
    end else if (ce) begin
      if (wr_tmo_lo) begin
        tmo_period[7:0] <= wr_data[7:0];
      end
      if (wr_tmo_hi) begin
        tmo_period[TMO_W-1:8] <= wr_data[TMO_W-9:0];
      end
    end
  end

  // timer control: run enable and restart on sync word
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tmo_ctrl <= `RIF_CTRL_RST;
    end else if (ce && wr_ctrl) begin
      tmo_ctrl <= wr_data[7:0];
    end
  end

  assign tmo_run     = tmo_ctrl[`RIF_CTRL_RUN] & rx_active;
  assign tmo_restart = packet_done_evt
                     | (tmo_ctrl[`RIF_CTRL_SYNC_RST] & sync_word_evt);
  assign tmo_last    = tmo_period - `RIF_CNT_STEP;

  // receive period counter; a zero period never expires
  always @* begin
    next_tmo_count = tmo_count;
    tmo_fire       = 1'b0;
    if (!tmo_run || tmo_restart) begin
      next_tmo_count = `RIF_CNT_RST;
    end else if (tmo_period != `RIF_TMO_NONE) begin
      if (tmo_count == tmo_last) begin
        tmo_fire       = 1'b1;
        next_tmo_count = `RIF_CNT_RST;
      end else begin
        next_tmo_count = tmo_count + `RIF_CNT_STEP;
      end
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tmo_count <= `RIF_CNT_RST;
    end else if (ce) begin
      tmo_count <= next_tmo_count;
    end
  end

  assign rx_timeout_pulse = tmo_fire & ce;

  // live event inputs, readable for debug
  assign raw_vec = {tx_underflow_evt, rx_overflow_evt, rx_timeout_evt,
                    packet_done_evt, carrier_sense_evt, preamble_quality_evt,
                    clear_channel_evt, sync_word_evt};

  // event to flag mapping; overrun and underflow also mark packet done
  always @* begin
    set_vec                   = 8'h00;
    set_vec[`RIF_BIT_TXUNF]   = tx_underflow_evt;
    set_vec[`RIF_BIT_RXOVF]   = rx_overflow_evt;
    set_vec[`RIF_BIT_TIMEOUT] = rx_timeout_evt | tmo_fire;
    set_vec[`RIF_BIT_DONE]    = packet_done_evt | rx_overflow_evt
                              | tx_underflow_evt;
    set_vec[`RIF_BIT_CS]      = carrier_sense_evt;
    set_vec[`RIF_BIT_PQT]     = preamble_quality_evt;
    set_vec[`RIF_BIT_CCA]     = clear_channel_evt;
    set_vec[`RIF_BIT_SFD]     = sync_word_evt;
  end

  // writing 0 clears a flag, writing 1 leaves it alone
  assign clr_vec = wr_pend ? ~wr_data[7:0] : 8'h00;

  // one sticky flag per source
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
      rif_flag_bit u_flag (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ce      (ce),
        .set     (set_vec[gi]),
        .clr     (clr_vec[gi]),
        .flag    (pend[gi])
      );
    end
  endgenerate

  assign radio_irq_pending_flags  = pend;
  assign tx_underflow_pending     = pend[`RIF_BIT_TXUNF];
  assign rx_overflow_pending      = pend[`RIF_BIT_RXOVF];
  assign preamble_quality_pending = pend[`RIF_BIT_PQT];
  assign clear_channel_pending    = pend[`RIF_BIT_CCA];
  assign sync_word_pending        = pend[`RIF_BIT_SFD];

  // level interrupt: any pending flag with its enable set
  assign radio_irq =
      (tx_underflow_pending     & tx_underflow_enable)
    | (rx_overflow_pending      & rx_overflow_enable)
    | (pend[`RIF_BIT_TIMEOUT]   & rx_timeout_enable)
    | (pend[`RIF_BIT_DONE]      & packet_done_enable)
    | (pend[`RIF_BIT_CS]        & carrier_sense_enable)
    | (preamble_quality_pending & preamble_quality_enable)
    | (clear_channel_pending    & clear_channel_enable)
    | (sync_word_pending        & sync_word_enable);

  // read multiplexer; unmapped addresses read zero
  always @* begin
    next_rd_data = `RIF_RD_UNMAPPED;
    if (rif_hit(addr, `RIF_ADDR_MASK)) begin
      next_rd_data = radio_irq_enable_mask;
    end else if (rif_hit(addr, `RIF_ADDR_PEND)) begin
      next_rd_data = pend;
    end else if (rif_hit(addr, `RIF_ADDR_TMO_LO)) begin
      next_rd_data = tmo_period[7:0];
    end else if (rif_hit(addr, `RIF_ADDR_TMO_HI)) begin
      next_rd_data = tmo_period[TMO_W-1:8];
    end else if (rif_hit(addr, `RIF_ADDR_TMO_CTRL)) begin
      next_rd_data = tmo_ctrl;
    end else if (rif_hit(addr, `RIF_ADDR_RAW)) begin
      next_rd_data = raw_vec;
    end else if (rif_hit(addr, `RIF_ADDR_CNT_LO)) begin
      next_rd_data = tmo_count[7:0];
    end else if (rif_hit(addr, `RIF_ADDR_CNT_HI)) begin
      next_rd_data = tmo_count[TMO_W-1:8];
    end
  end

  // read data stands for the one cycle after the strobe
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data <= `RIF_RD_RST;
    end else if (ce) begin
      if (rd_stb) begin
        rd_data <= next_rd_data;
      end else begin
        rd_data <= `RIF_RD_RST;
      end
    end
  end

endmodule // rif_top
